// ===== pkg/mso_pkg.sv
/*
 * Package for the multiply, negate and stack execution slice of the core.
 * Assumes one clock, a synchronous active-low reset and an AXI4-Lite register bus.
 */
package mso_pkg;
    // Opcode patterns, compared against the upper bits of the instruction word, or for 16-bit patterns the whole word.
    localparam logic [7:0] OPC_MUL_LIT = 8'h0d;  // Multiply literal: upper byte.
    localparam logic [6:0] OPC_MUL_FILE = 7'h01;  // Multiply file: bits 15..9.
    localparam logic [6:0] OPC_NEG_FILE = 7'h36;  // Negate file: bits 15..9.
    localparam logic [4:0] OPC_REL_CALL = 5'h1b;  // Relative call: bits 15..11.
    localparam logic [15:0] OPC_NOP = 16'h0000;  // No operation.
    localparam logic [15:0] OPC_POP = 16'h0006;  // Pop stack.
    localparam logic [15:0] OPC_PUSH = 16'h0005;  // Push stack.
    localparam logic [15:0] OPC_SWRST = 16'h00ff;  // Software reset.
    localparam logic [3:0] OPC_NOP_ALT = 4'hf;  // Second-word no operation.
    // Addressing constants.
    localparam logic [7:0] IDX_LIMIT = 8'h5f;  // Offsets at or below are indexed.
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;  // Access bank low/high split.
    localparam logic [3:0] SFR_BANK = 4'hf;  // Bank for upper access half.
    localparam int PC_STEP = 2;  // Bytes per program word.
    // Register byte offsets.
    localparam logic [7:0] ADDR_INSN = 8'h00;  // Write: execute instruction.
    localparam logic [7:0] ADDR_WREG = 8'h04;  // Working register.
    localparam logic [7:0] ADDR_BANK = 8'h08;  // Bank select.
    localparam logic [7:0] ADDR_PROD = 8'h0c;  // Product pair, high byte in 15..8.
    localparam logic [7:0] ADDR_STAT = 8'h10;  // Flags.
    localparam logic [7:0] ADDR_PC = 8'h14;  // Program counter.
    localparam logic [7:0] ADDR_STACK_TOP = 8'h18;  // Stack top.
    localparam logic [7:0] ADDR_CTRL = 8'h1c;  // Bit 0: extended set, bits 15..8 index base.
    localparam logic [7:0] ADDR_MEM = 8'h20;  // Bits 11..0 address, then data window at 0x24.
    localparam logic [7:0] ADDR_MDAT = 8'h24;  // Data at the memory pointer.
    localparam logic [7:0] ADDR_BUSY = 8'h28;  // Bit 0: instruction in progress.
    // Status bit positions.
    localparam int ST_C = 0;
    localparam int ST_DIGIT_CARRY = 1;
    localparam int ST_Z = 2;
    localparam int ST_OVERFLOW = 3;
    localparam int ST_N = 4;
    // Reset value and bus response codes.
    localparam logic [20:0] PC_RST = 21'h000000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Execution phases: four per instruction cycle.
    typedef enum logic [4:0] {
        PH_IDLE = 5'b00001,
        PH_Q1 = 5'b00010,
        PH_Q2 = 5'b00100,
        PH_Q3 = 5'b01000,
        PH_Q4 = 5'b10000
    } mso_phase_t;
endpackage : mso_pkg

// ===== hdl/mso_core.sv
/*
 * Execution slice for multiply, negate, stack and software reset instructions.
 * An instruction written over AXI4-Lite runs through four phases per instruction cycle.
 * Assumes a single 50 MHz clock aclk and a synchronous active-low reset aresetn.
 */
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
// Notes on behaviour
// - Literal multiply: W times k into product
// - File multiply: W times f, sources kept
// - Multiplies leave every status flag untouched
// - Access bit zero: access bank; one: bank
// - Extended set, offset <=95: indexed literal offset
// - Negate file: two's complement, five flags updated
// - Pop discards top, previous entry resurfaces
// - Push places PC plus two on stack
// - Relative call pushes, jumps, takes two cycles
// - Software reset clears the architectural state that external reset clears, except the memory pointer
// - Multiplies: one word, one cycle, write Q4
`timescale 1ns/100ps
module mso_core #(
    parameter int DEPTH = 31,  // Return stack depth.
    parameter int MEM_WORDS = 4096  // Data memory size in bytes.
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import mso_pkg::*;

    localparam int SPW = $clog2(DEPTH + 1);  // Stack pointer width.

    // Architectural state.
    logic [7:0] wreg_reg, wreg_next;  // Working register.
    logic [7:0] bank_select_reg, bank_next;  // Bank select register.
    logic [7:0] product_high_byte, prod_hi_next;  // Product high byte.
    logic [7:0] product_low_byte, prod_lo_next;  // Product low byte.
    logic [4:0] stat_reg, stat_next;  // Negative, overflow, zero, digit carry, carry.
    logic [20:0] pc_reg, pc_next;  // Program counter.
    logic [20:0] stk [DEPTH];  // Return stack; entry sp-1 is the top.
    logic [SPW-1:0] sp_reg, sp_next;  // Number of entries held.
    logic stk_we;  // Write strobe for the stack array.
    logic [20:0] stk_wd;  // Data written to the stack.
    logic [7:0] mem [MEM_WORDS];  // Banked data memory.
    logic mem_we;  // Memory write strobe.
    logic [11:0] mem_wa;  // Memory write address.
    logic [7:0] mem_wd;  // Memory write data.
    logic ext_reg, ext_next;  // Extended instruction set enable.
    logic [7:0] fsr_reg, fsr_next;  // Base for indexed literal offset.
    logic [11:0] mptr_reg, mptr_next;  // Software memory pointer.
    // Execution sequencing.
    mso_phase_t ph_reg, ph_next;
    logic [15:0] insn_reg, insn_next;  // Instruction being executed.
    logic second_reg, second_next;  // Second cycle of a two-cycle op.
    logic [7:0] opnd_reg, opnd_next;  // Operand read in Q2.
    // Bus state.
    logic bvalid_reg, bvalid_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] bresp_reg, bresp_next;
    logic [1:0] rresp_reg, rresp_next;
    logic stk_top_valid;
    logic [20:0] stack_top;
    logic [11:0] faddr;  // Resolved file address.
    logic [7:0] fofs;  // File offset field.
    logic [7:0] neg_res;  // Negate result.
    logic [15:0] mul_res;  // Product.
    logic wr_go;  // Write address and data both present.

    assign stk_top_valid = (sp_reg != '0);
    assign stack_top = stk_top_valid ? stk[sp_reg - SPW'(1)] : '0;
    assign fofs = insn_reg[7:0];

    // Resolve the file address from the access bit and the mode.
    always_comb begin
        if (insn_reg[8]) begin
            faddr = {bank_select_reg[3:0], fofs};
        end else if (ext_reg && (fofs <= IDX_LIMIT)) begin
            faddr = {4'h0, fsr_reg + fofs};
        end else if (fofs < ACCESS_SPLIT) begin
            faddr = {4'h0, fofs};
        end else begin
            faddr = {SFR_BANK, fofs};
        end
    end

    assign mul_res = wreg_reg * (insn_reg[15:8] == OPC_MUL_LIT ? insn_reg[7:0] : opnd_reg);
    assign neg_res = 8'(~opnd_reg + 8'h01);
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;

    // Bus handshakes are combinational; both channels taken together.
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = s_axi_arvalid && !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Next state: bus, execution and software reset in one place.
    // Only one instruction runs at a time; writes to INSN while busy get SLVERR.
    always_comb begin
        wreg_next = wreg_reg;
        bank_next = bank_select_reg;
        prod_hi_next = product_high_byte;
        prod_lo_next = product_low_byte;
        stat_next = stat_reg;
        pc_next = pc_reg;
        sp_next = sp_reg;
        stk_we = 1'b0;
        stk_wd = '0;
        mem_we = 1'b0;
        mem_wa = faddr;
        mem_wd = neg_res;
        ext_next = ext_reg;
        fsr_next = fsr_reg;
        mptr_next = mptr_reg;
        ph_next = ph_reg;
        insn_next = insn_reg;
        second_next = second_reg;
        opnd_next = opnd_reg;
        bvalid_next = bvalid_reg && !s_axi_bready;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg && !s_axi_rready;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        // Phase sequencer.
        case (ph_reg)
            PH_IDLE: ph_next = PH_IDLE;
            PH_Q1: ph_next = PH_Q2;
            PH_Q2: begin
                opnd_next = mem[faddr];  // Read register f.
                ph_next = PH_Q3;
            end
            PH_Q3: ph_next = PH_Q4;
            PH_Q4: begin
                ph_next = PH_IDLE;
                if (second_reg) begin
                    second_next = 1'b0;
                end else if (insn_reg[15:8] == OPC_MUL_LIT) begin
                    {prod_hi_next, prod_lo_next} = mul_res;
                    pc_next = 21'(pc_reg + PC_STEP);
                end else if (insn_reg[15:9] == OPC_MUL_FILE) begin
                    {prod_hi_next, prod_lo_next} = mul_res;
                    pc_next = 21'(pc_reg + PC_STEP);
                end else if (insn_reg[15:9] == OPC_NEG_FILE) begin
                    mem_we = 1'b1;
                    stat_next[ST_N] = neg_res[7];
                    stat_next[ST_Z] = (neg_res == 8'h00);
                    stat_next[ST_C] = (opnd_reg == 8'h00);
                    stat_next[ST_DIGIT_CARRY] = (opnd_reg[3:0] == 4'h0);
                    stat_next[ST_OVERFLOW] = (opnd_reg == 8'h80);
                    pc_next = 21'(pc_reg + PC_STEP);
                end else if (insn_reg[15:11] == OPC_REL_CALL) begin
                    stk_we = (sp_reg < SPW'(DEPTH));
                    stk_wd = 21'(pc_reg + PC_STEP);
                    sp_next = stk_we ? SPW'(sp_reg + 1'b1) : sp_reg;
                    pc_next = 21'(pc_reg + PC_STEP + {{9{insn_reg[10]}}, insn_reg[10:0], 1'b0});
                    second_next = 1'b1;
                    ph_next = PH_Q1;
                end else if (insn_reg == OPC_POP) begin
                    sp_next = stk_top_valid ? SPW'(sp_reg - 1'b1) : sp_reg;
                    pc_next = 21'(pc_reg + PC_STEP);
                end else if (insn_reg == OPC_PUSH) begin
                    stk_we = (sp_reg < SPW'(DEPTH));
                    stk_wd = 21'(pc_reg + PC_STEP);
                    sp_next = stk_we ? SPW'(sp_reg + 1'b1) : sp_reg;
                    pc_next = 21'(pc_reg + PC_STEP);
                end else if (insn_reg == OPC_SWRST) begin
                    wreg_next = '0;
                    bank_next = '0;
                    prod_hi_next = '0;
                    prod_lo_next = '0;
                    stat_next = '0;
                    pc_next = PC_RST;
                    sp_next = '0;
                    ext_next = 1'b0;
                    fsr_next = '0;
                end else begin
                    pc_next = 21'(pc_reg + PC_STEP);
                end
            end
            default: ph_next = PH_IDLE;
        endcase
        // Register writes.
        if (wr_go) begin
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            case (s_axi_awaddr)
                ADDR_INSN: begin
                    if (ph_reg == PH_IDLE) begin
                        insn_next = s_axi_wdata[15:0];
                        ph_next = PH_Q1;
                    end else begin
                        bresp_next = RESP_SLVERR;  // Busy: refused.
                    end
                end
                ADDR_WREG: if (s_axi_wstrb[0]) wreg_next = s_axi_wdata[7:0];
                ADDR_BANK: if (s_axi_wstrb[0]) bank_next = {4'h0, s_axi_wdata[3:0]};
                // Flags are writable so software can preload them; a bus write beats Q4.
                ADDR_STAT: if (s_axi_wstrb[0]) stat_next = s_axi_wdata[4:0];
                ADDR_PC: pc_next = {s_axi_wdata[20:1], 1'b0};
                ADDR_CTRL: begin
                    if (s_axi_wstrb[0]) ext_next = s_axi_wdata[0];
                    if (s_axi_wstrb[1]) fsr_next = s_axi_wdata[15:8];
                end
                ADDR_MEM: mptr_next = s_axi_wdata[11:0];
                ADDR_MDAT: begin
                    if (s_axi_wstrb[0] && !mem_we) begin
                        mem_we = 1'b1;
                        mem_wa = mptr_reg;
                        mem_wd = s_axi_wdata[7:0];
                    end
                end
                default: bresp_next = RESP_SLVERR;
            endcase
        end
        // Register reads.
        if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            case (s_axi_araddr)
                ADDR_INSN: rdata_next = {16'h0000, insn_reg};
                ADDR_WREG: rdata_next = {24'h000000, wreg_reg};
                ADDR_BANK: rdata_next = {24'h000000, bank_select_reg};
                ADDR_PROD: rdata_next = {16'h0000, product_high_byte, product_low_byte};
                ADDR_STAT: rdata_next = {27'h0000000, stat_reg};
                ADDR_PC: rdata_next = {11'h000, pc_reg};
                ADDR_STACK_TOP: rdata_next = {11'h000, stack_top};
                ADDR_CTRL: rdata_next = {16'h0000, fsr_reg, 7'h00, ext_reg};
                ADDR_MEM: rdata_next = {20'h00000, mptr_reg};
                ADDR_MDAT: rdata_next = {24'h000000, mem[mptr_reg]};
                ADDR_BUSY: rdata_next = {31'h00000000, ph_reg != PH_IDLE};
                default: begin
                    rdata_next = '0;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
    end

    // Register all state; memories are written without reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wreg_reg <= '0;
            bank_select_reg <= '0;
            product_high_byte <= '0;
            product_low_byte <= '0;
            stat_reg <= '0;
            pc_reg <= PC_RST;
            sp_reg <= '0;
            ext_reg <= 1'b0;
            fsr_reg <= '0;
            mptr_reg <= '0;
            ph_reg <= PH_IDLE;
            insn_reg <= '0;
            second_reg <= 1'b0;
            opnd_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else begin
            wreg_reg <= wreg_next;
            bank_select_reg <= bank_next;
            product_high_byte <= prod_hi_next;
            product_low_byte <= prod_lo_next;
            stat_reg <= stat_next;
            pc_reg <= pc_next;
            sp_reg <= sp_next;
            ext_reg <= ext_next;
            fsr_reg <= fsr_next;
            mptr_reg <= mptr_next;
            ph_reg <= ph_next;
            insn_reg <= insn_next;
            second_reg <= second_next;
            opnd_reg <= opnd_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // Arrays are plain storage; no reset keeps them inferable as RAM.
    always_ff @(posedge aclk) begin
        if (stk_we) begin
            stk[sp_reg] <= stk_wd;
        end
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Checks.
    // Both multiplies are covered; a bus write to the flags in Q4 is excluded since it wins.
    property p_mul_flags;
        @(posedge aclk) disable iff (!aresetn)
        (ph_reg == PH_Q4 && !second_reg && !wr_go
            && (insn_reg[15:8] == OPC_MUL_LIT || insn_reg[15:9] == OPC_MUL_FILE))
            |=> $stable(stat_reg);
    endproperty
    a_mul_flags: assert property (p_mul_flags) else $error("multiply changed flags");
    // Operands are widened before the product so no tool can truncate it to 8 bits.
    property p_mul_lit;
        @(posedge aclk) disable iff (!aresetn)
        (ph_reg == PH_Q4 && !second_reg && insn_reg[15:8] == OPC_MUL_LIT)
            |=> {product_high_byte, product_low_byte} == 16'($past(wreg_reg)) * 16'($past(insn_reg[7:0]));
    endproperty
    a_mul_lit: assert property (p_mul_lit) else $error("literal product wrong");
    property p_one_cycle;
        @(posedge aclk) disable iff (!aresetn)
        (ph_reg == PH_Q1 && !second_reg && insn_reg[15:11] != OPC_REL_CALL)
            |-> ##3 (ph_reg == PH_Q4) ##1 (ph_reg == PH_IDLE);
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("single-cycle op overran");
    sequence s_call_first;
        ph_reg == PH_Q4 && !second_reg && insn_reg[15:11] == OPC_REL_CALL;
    endsequence
    property p_rel_call;
        @(posedge aclk) disable iff (!aresetn)
        s_call_first |=> (ph_reg == PH_Q1 && second_reg) ##3 (ph_reg == PH_Q4) ##1 (ph_reg == PH_IDLE);
    endproperty
    a_rel_call: assert property (p_rel_call) else $error("relative call not two cycles");
    property p_push;
        @(posedge aclk) disable iff (!aresetn)
        (ph_reg == PH_Q4 && insn_reg == OPC_PUSH && sp_reg < SPW'(DEPTH) && !wr_go)
            |=> stack_top == 21'($past(pc_reg) + PC_STEP);
    endproperty
    a_push: assert property (p_push) else $error("push value wrong");
    property p_pop;
        @(posedge aclk) disable iff (!aresetn)
        (ph_reg == PH_Q4 && insn_reg == OPC_POP && stk_top_valid) |=> sp_reg == SPW'($past(sp_reg) - 1'b1);
    endproperty
    a_pop: assert property (p_pop) else $error("pop did not drop top");
    property p_neg_z;
        @(posedge aclk) disable iff (!aresetn)
        (ph_reg == PH_Q4 && !second_reg && insn_reg[15:9] == OPC_NEG_FILE && !wr_go)
            |=> stat_reg[ST_Z] == ($past(opnd_reg) == 8'h00);
    endproperty
    a_neg_z: assert property (p_neg_z) else $error("negate zero flag wrong");
    property p_swrst;
        @(posedge aclk) disable iff (!aresetn)
        (ph_reg == PH_Q4 && !second_reg && insn_reg == OPC_SWRST && !wr_go)
            |=> (pc_reg == PC_RST && sp_reg == '0 && stat_reg == '0);
    endproperty
    a_swrst: assert property (p_swrst) else $error("software reset incomplete");
    property p_nop;
        @(posedge aclk) disable iff (!aresetn)
        (ph_reg == PH_Q4 && !second_reg && insn_reg == OPC_NOP && !wr_go)
            |=> $stable(wreg_reg) && $stable(stat_reg) && $stable(sp_reg);
    endproperty
    a_nop: assert property (p_nop) else $error("no-op changed state");
    property p_bank;
        @(posedge aclk) disable iff (!aresetn)
        insn_reg[8] |-> faddr[11:8] == bank_select_reg[3:0];
    endproperty
    a_bank: assert property (p_bank) else $error("bank select not used");
    property p_idx;
        @(posedge aclk) disable iff (!aresetn)
        (!insn_reg[8] && ext_reg && fofs <= IDX_LIMIT) |-> faddr == {4'h0, 8'(fsr_reg + fofs)};
    endproperty
    a_idx: assert property (p_idx) else $error("indexed offset wrong");
    property p_mul_file;
        @(posedge aclk) disable iff (!aresetn)
        (ph_reg == PH_Q4 && !second_reg && insn_reg[15:9] == OPC_MUL_FILE && !wr_go)
            |=> $stable(wreg_reg)
            && {product_high_byte, product_low_byte} == 16'($past(wreg_reg)) * 16'($past(opnd_reg));
    endproperty
    a_mul_file: assert property (p_mul_file) else $error("multiply file wrong or changed W");
endmodule : mso_core

// ===== verif/mso_axi_host.sv
/* Register-bus partner: AXI4-Lite master tasks for the execution slice.
   Assumes one clock and a slave that answers every accepted request once. */
`timescale 1ns/100ps
module mso_axi_host (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    output logic hung
);
    // Everything idle from time zero so reset sees no request.
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready, hung} = '0;
        wstrb = 4'hf;
    end

    // Address and data are offered together; each is released at the edge where its own ready is seen.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        logic aw_ok, w_ok;
        i = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) aw_ok = 1'b1;
            if (wready) w_ok = 1'b1;
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end while (!(aw_ok && w_ok) && ++i < 100);
        while (!bvalid && i < 100) @(posedge aclk) i++;
        r = bresp;
        bready <= 1'b0;
        if (i >= 100) hung <= 1'b1;
    endtask : wr

    // The read response is taken at the edge where rvalid is seen high.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        i = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready && ++i < 100);
        arvalid <= 1'b0;
        while (!rvalid && i < 100) @(posedge aclk) i++;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (i >= 100) hung <= 1'b1;
    endtask : rd
endmodule : mso_axi_host

// ===== verif/test_cpu_multiply_stack_call_ops.sv
/* Self-checking bench: drives instructions over the register bus and compares with a queue model.
   Assumes the bus partner in mso_axi_host and a 50 MHz clock. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_cpu_multiply_stack_call_ops;
    import mso_pkg::*;
    logic aclk, aresetn, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, hung;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat, v;
    logic [3:0] ws;
    logic [1:0] bre, rre, r;
    logic [7:0] w, k, m, res;
    logic [11:0] ea;
    logic [4:0] fl;
    logic [31:0] seed;
    int pc, ret, fails, n_tests, i;
    int stk[$];
    // Operand table for the file operations: boundary values of negation.
    logic [7:0] vt[6] = '{8'h3a, 8'h00, 8'h80, 8'h01, 8'hff, 8'h5c};
    logic [7:0] ft[6] = '{8'h34, 8'h10, 8'h70, 8'h10, 8'h60, 8'h5f};
    logic at[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    logic xt[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

    mso_core u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bre),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr));
    mso_axi_host u_host (.aclk(aclk), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wd), .wstrb(ws),
        .wvalid(wv), .wready(wr_), .bresp(bre), .bvalid(bv), .bready(br), .araddr(ara), .arvalid(arv),
        .arready(arr), .rdata(rdat), .rresp(rre), .rvalid(rv), .rready(rr), .hung(hung));

    // Pseudo-random source for operands.
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    task automatic test_done();
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        u_host.wr(a, d, r);
        `CHK(r, RESP_OKAY)
    endtask : wreg

    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        u_host.rd(a, v, r);
        `CHK(v, e)
    endtask : rreg

    // Runs one instruction, polls busy with a bound, then checks the program counter.
    task automatic exec(input logic [15:0] insn, input int jmp);
        int n;
        wreg(ADDR_INSN, {16'h0, insn});
        for (n = 0; n < 40; n++) begin
            u_host.rd(ADDR_BUSY, v, r);
            if (v[0] === 1'b0) break;
        end
        if (n == 40) begin
            fails++;
            test_done();
        end
        // The program counter is 21 bits wide, so the model wraps the same way.
        pc = (pc + 2 + jmp) & 32'h1fffff;
        rreg(ADDR_PC, 32'(pc));
    endtask : exec

    // A hung bus wait ends the run.
    always @(posedge hung) begin
        fails++;
        test_done();
    end

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    initial begin
        aresetn = 1'b0;
        pc = 0;
        seed = 32'he133;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rreg(ADDR_STACK_TOP, 32'h0);
        fl = 5'h15;
        wreg(ADDR_STAT, 32'(fl));
        // Literal multiplies, the first with a zero operand.
        for (i = 0; i < 4; i++) begin
            seed = nxt(seed);
            w = (i == 0) ? 8'h00 : seed[7:0];
            k = seed[15:8];
            wreg(ADDR_WREG, 32'(w));
            exec({OPC_MUL_LIT, k}, 0);
            rreg(ADDR_PROD, 32'(w) * 32'(k));
            rreg(ADDR_WREG, 32'(w));
            rreg(ADDR_STAT, 32'(fl));
        end
        // File multiply then negate across every addressing case.
        wreg(ADDR_BANK, 32'h2);
        for (i = 0; i < 6; i++) begin
            m = vt[i];
            wreg(ADDR_CTRL, {16'h0, 8'h20, 7'h0, xt[i]});
            ea = at[i] ? {4'h2, ft[i]} : (xt[i] && ft[i] <= IDX_LIMIT) ? {4'h0, 8'h20 + ft[i]} :
                (ft[i] < ACCESS_SPLIT) ? {4'h0, ft[i]} : {SFR_BANK, ft[i]};
            wreg(ADDR_MEM, 32'(ea));
            wreg(ADDR_MDAT, 32'(m));
            exec({OPC_MUL_FILE, at[i], ft[i]}, 0);
            rreg(ADDR_PROD, 32'(w) * 32'(m));
            rreg(ADDR_MDAT, 32'(m));
            rreg(ADDR_STAT, 32'(fl));
            exec({OPC_NEG_FILE, at[i], ft[i]}, 0);
            res = 8'h00 - m;
            fl = {res[7], m == 8'h80, res == 8'h00, m[3:0] == 4'h0, m == 8'h00};
            rreg(ADDR_MDAT, 32'(res));
            rreg(ADDR_STAT, 32'(fl));
        end
        // Stack: two pushes, a pop, calls at both offset limits.
        pc = 32'h124;
        wreg(ADDR_PC, 32'(pc));
        for (i = 0; i < 2; i++) begin
            exec(OPC_PUSH, 0);
            stk.push_front(pc);
            rreg(ADDR_STACK_TOP, 32'(stk[0]));
        end
        exec(OPC_POP, 0);
        void'(stk.pop_front());
        rreg(ADDR_STACK_TOP, 32'(stk[0]));
        ret = pc + 2;
        exec({OPC_REL_CALL, 11'h400}, -2048);
        stk.push_front(ret);
        rreg(ADDR_STACK_TOP, 32'(stk[0]));
        ret = pc + 2;
        exec({OPC_REL_CALL, 11'h3ff}, 2046);
        stk.push_front(ret);
        rreg(ADDR_STACK_TOP, 32'(stk[0]));
        exec(OPC_NOP, 0);
        rreg(ADDR_STACK_TOP, 32'(stk[0]));
        rreg(ADDR_STAT, 32'(fl));
        rreg(ADDR_PROD, 32'(w) * 32'(m));
        // A second instruction written while one is still running is refused.
        u_host.wr(ADDR_INSN, {16'h0, OPC_NOP}, r);
        u_host.wr(ADDR_INSN, {16'h0, OPC_NOP}, r);
        `CHK(r, RESP_SLVERR)
        // Software reset clears the core state.
        exec(OPC_SWRST, -pc - 2);
        rreg(ADDR_WREG, 32'h0);
        rreg(ADDR_PROD, 32'h0);
        rreg(ADDR_STAT, 32'h0);
        rreg(ADDR_STACK_TOP, 32'h0);
        rreg(ADDR_BANK, 32'h0);
        u_host.rd(8'h3c, v, r);
        `CHK(r, RESP_SLVERR)
        test_done();
    end
endmodule : test_cpu_multiply_stack_call_ops
